// File: logic/jtag_defines.svh
// Purpose: constants for the test access port instruction logic
// Assumes: six-bit instruction register, 32-bit identity word
// Notes:   identity fields are parameters of the top module
`ifndef JTAG_DEFINES_SVH
`define JTAG_DEFINES_SVH

`define IR_WIDTH          6
`define IR_EXTEST         6'h00
`define IR_SAMPLE         6'h01
`define IR_IDCODE         6'h02
`define IR_HIGHZ          6'h03
`define IR_CAPTURE_IR_DEFAULT_PATTERN       6'h2d
`define IR_CLAMP          6'h3e
`define IR_BYPASS         6'h3f
`define ID_WIDTH          32
`define ID_LSB_POS        0
`define ID_MAKER_LO       1
`define ID_PART_LO        12
`define ID_REV_LO         28
`define BSR_WIDTH         8
`define BYPASS_CAPTURE    1'b0

`endif

// File: logic/jtag_pkg.sv
// Purpose: shared types for the test access port logic
// Assumes: nothing beyond the defines header
// Notes:   pin group travels as one struct
package jtag_pkg;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_evt_t;

endpackage : jtag_pkg

// File: logic/tap_pin_sync.sv
// Purpose: bring the tester pins into the system clock domain
// Assumes: link clock far slower than sys_clk_in
// Notes:   edges found on the second stage only
`timescale 1ns/100ps
module tap_pin_sync (
  input  wire logic               sys_clk_in,
  input  wire logic               nrst_in,
  input  wire jtag_pkg::tap_pins_t pins_in,
  output      jtag_pkg::tap_evt_t  evt_out
);
  import jtag_pkg::*;

  tap_pins_t meta_ff;
  tap_pins_t sync_ff;
  logic      tck_old_ff;

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      meta_ff    <= '0;
      sync_ff    <= '0;
      tck_old_ff <= 1'b0;
    end else begin
      meta_ff    <= pins_in;
      sync_ff    <= meta_ff;
      tck_old_ff <= sync_ff.tck;
    end
  end

  always_comb begin
    evt_out.rise   = sync_ff.tck & ~tck_old_ff;
    evt_out.fall   = ~sync_ff.tck & tck_old_ff;
    evt_out.tms    = sync_ff.tms;
    evt_out.tdi    = sync_ff.tdi;
    evt_out.trst_n = sync_ff.trst_n;
  end

endmodule : tap_pin_sync

// File: logic/tap_fsm.sv
// Purpose: sixteen-state test access port controller
// Assumes: rise is one sys_clk_in pulse per test clock rising edge
// Notes:   test reset forces the reset state at once
`timescale 1ns/100ps
module tap_fsm (
  input  wire logic                sys_clk_in,
  input  wire logic                nrst_in,
  input  wire logic                rise_in,
  input  wire logic                tms_in,
  input  wire logic                trst_n_in,
  output      jtag_pkg::tap_state_t state_out
);
  import jtag_pkg::*;

  tap_state_t state_ff;
  tap_state_t nxt_state;

  assign state_out = state_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET:    nxt_state = tms_in ? ST_RESET    : ST_IDLE;
      ST_IDLE:     nxt_state = tms_in ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   nxt_state = tms_in ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   nxt_state = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: nxt_state = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: nxt_state = tms_in ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: nxt_state = tms_in ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: nxt_state = tms_in ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   nxt_state = tms_in ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   nxt_state = tms_in ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   nxt_state = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: nxt_state = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: nxt_state = tms_in ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: nxt_state = tms_in ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: nxt_state = tms_in ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   nxt_state = tms_in ? ST_SEL_DR   : ST_IDLE;
      default:     nxt_state = ST_RESET;
    endcase
  end

  // five rises with mode select high always land in reset
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in || !trst_n_in) begin
      state_ff <= ST_RESET;
    end else if (rise_in) begin
      state_ff <= nxt_state;
    end
  end

endmodule : tap_fsm

// File: logic/jtag_instruction_logic.sv
// Purpose: instruction register, data registers and scan output
// Assumes: tester pins asynchronous to sys_clk_in, tck of 80 ns
// Notes:   boundary chain is a small stand-in of twice BSR_WIDTH cells
`timescale 1ns/100ps
`include "jtag_defines.svh"
module jtag_instruction_logic #(
  parameter logic [10:0] MAKER_FIELD = 11'h155, // arbitrary value
  parameter logic [15:0] PART_FIELD  = 16'h1234, // arbitrary value
  parameter logic [3:0]  REV_FIELD   = 4'h1     // arbitrary value
) (
  input  wire logic                     sys_clk_in,
  input  wire logic                     nrst_in,
  input  wire jtag_pkg::tap_pins_t      pins_in,
  input  wire logic [`BSR_WIDTH-1:0]    core_out_in,
  input  wire logic [`BSR_WIDTH-1:0]    core_oe_in,
  input  wire logic [`BSR_WIDTH-1:0]    pad_in,
  output      logic                     tdo_out,
  output      logic                     tdo_oe_out,
  output      logic [`BSR_WIDTH-1:0]    pad_out,
  output      logic [`BSR_WIDTH-1:0]    pad_oe_out,
  output      logic [`IR_WIDTH-1:0]     instr_out,
  output      logic                     reserved_sel_out
);
  import jtag_pkg::*;

  localparam int BSR_LEN = 2 * `BSR_WIDTH;

  // ----------------------------------------------------------------
  // identity word
  // ----------------------------------------------------------------
  function automatic logic [`ID_WIDTH-1:0] identity_word();
    logic [`ID_WIDTH-1:0] w;
    w = '0;
    w[`ID_LSB_POS]                   = 1'b1;
    w[`ID_PART_LO-1:`ID_MAKER_LO]    = MAKER_FIELD;
    w[`ID_REV_LO-1:`ID_PART_LO]      = PART_FIELD;
    w[`ID_WIDTH-1:`ID_REV_LO]        = REV_FIELD;
    return w;
  endfunction : identity_word

  function automatic logic is_reserved(input logic [`IR_WIDTH-1:0] c);
    is_reserved = !(c == `IR_EXTEST || c == `IR_SAMPLE
                 || c == `IR_IDCODE || c == `IR_HIGHZ
                 || c == `IR_CAPTURE_IR_DEFAULT_PATTERN || c == `IR_CLAMP
                 || c == `IR_BYPASS);
  endfunction : is_reserved

  // ----------------------------------------------------------------
  // pin synchroniser and controller
  // ----------------------------------------------------------------
  tap_evt_t   evt;
  tap_state_t state;

  tap_pin_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .pins_in    (pins_in),
    .evt_out    (evt)
  );

  tap_fsm u_fsm (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .rise_in    (evt.rise),
    .tms_in     (evt.tms),
    .trst_n_in  (evt.trst_n),
    .state_out  (state)
  );

  logic                  tap_rst;
  logic [`IR_WIDTH-1:0]  ir_shift_ff;
  logic [`IR_WIDTH-1:0]  ir_ff;
  logic [`ID_WIDTH-1:0]  id_shift_ff;
  logic                  bypass_ff;
  logic [BSR_LEN-1:0]    bsr_shift_ff;
  logic [BSR_LEN-1:0]    bsr_upd_ff;
  logic                  serial_bit;
  logic                  sel_bypass;
  logic                  sel_bsr;
  logic                  drive_pins;
  logic [`BSR_WIDTH-1:0] pad_meta_ff;
  logic [`BSR_WIDTH-1:0] pad_sync_ff;

  // pad levels are board side, so two flops before the capture cells
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pad_meta_ff <= '0;
      pad_sync_ff <= '0;
    end else begin
      pad_meta_ff <= pad_in;
      pad_sync_ff <= pad_meta_ff;
    end
  end

  assign tap_rst = !nrst_in || !evt.trst_n || state == ST_RESET;

  // reserved codes fall back to bypass as the data path
  assign sel_bypass = ir_ff == `IR_BYPASS || ir_ff == `IR_CLAMP
                   || ir_ff == `IR_HIGHZ || is_reserved(ir_ff);
  assign sel_bsr    = ir_ff == `IR_EXTEST || ir_ff == `IR_SAMPLE;
  assign drive_pins = ir_ff == `IR_EXTEST || ir_ff == `IR_CLAMP;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (tap_rst) begin
      ir_shift_ff <= `IR_CAPTURE_IR_DEFAULT_PATTERN;
    end else if (evt.rise) begin
      if (state == ST_CAP_IR) begin
        ir_shift_ff <= `IR_CAPTURE_IR_DEFAULT_PATTERN;
      end else if (state == ST_SHIFT_IR) begin
        ir_shift_ff <= {evt.tdi, ir_shift_ff[`IR_WIDTH-1:1]};
      end
    end
  end

  // idcode is current after any reset, never bypass
  always_ff @(posedge sys_clk_in) begin
    if (tap_rst) begin
      ir_ff <= `IR_IDCODE;
    end else if (evt.rise && state == ST_UPD_IR) begin
      ir_ff <= ir_shift_ff;
    end
  end

  // ----------------------------------------------------------------
  // identity and bypass registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (tap_rst) begin
      id_shift_ff <= identity_word();
    end else if (evt.rise && ir_ff == `IR_IDCODE) begin
      if (state == ST_CAP_DR) begin
        id_shift_ff <= identity_word();
      end else if (state == ST_SHIFT_DR) begin
        id_shift_ff <= {evt.tdi, id_shift_ff[`ID_WIDTH-1:1]};
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (tap_rst) begin
      bypass_ff <= `BYPASS_CAPTURE;
    end else if (evt.rise && sel_bypass) begin
      if (state == ST_CAP_DR) begin
        bypass_ff <= `BYPASS_CAPTURE;
      end else if (state == ST_SHIFT_DR) begin
        bypass_ff <= evt.tdi;
      end
    end
  end

  // ----------------------------------------------------------------
  // boundary chain: low half data cells, high half enable cells
  // ----------------------------------------------------------------
  logic [BSR_LEN-1:0] snapshot;
  always_comb begin
    for (int i = 0; i < `BSR_WIDTH; i++) begin
      // while pins are not driven an enabled pin reports the core value, else the pad
      snapshot[i] = (core_oe_in[i] && !drive_pins) ? core_out_in[i]
                                                   : pad_sync_ff[i];
    end
    snapshot[BSR_LEN-1:`BSR_WIDTH] = core_oe_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (tap_rst) begin
      bsr_shift_ff <= '0;
    end else if (evt.rise && sel_bsr) begin
      if (state == ST_CAP_DR) begin
        bsr_shift_ff <= snapshot;
      end else if (state == ST_SHIFT_DR) begin
        bsr_shift_ff <= {evt.tdi, bsr_shift_ff[BSR_LEN-1:1]};
      end
    end
  end

  // latched cells; clamp keeps them frozen
  always_ff @(posedge sys_clk_in) begin
    if (tap_rst) begin
      bsr_upd_ff <= '0;
    end else if (evt.rise && sel_bsr && state == ST_UPD_DR) begin
      bsr_upd_ff <= bsr_shift_ff;
    end
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      pad_out    <= '0;
      pad_oe_out <= '0;
    end else if (drive_pins && !tap_rst) begin
      pad_out    <= bsr_upd_ff[`BSR_WIDTH-1:0];
      pad_oe_out <= bsr_upd_ff[BSR_LEN-1:`BSR_WIDTH];
    end else if (ir_ff == `IR_HIGHZ && !tap_rst) begin
      pad_out    <= core_out_in;
      pad_oe_out <= '0;
    end else begin
      pad_out    <= core_out_in;
      pad_oe_out <= core_oe_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      instr_out        <= `IR_IDCODE;
      reserved_sel_out <= 1'b0;
    end else begin
      instr_out        <= ir_ff;
      reserved_sel_out <= is_reserved(ir_ff);
    end
  end

  // ----------------------------------------------------------------
  // serial output on the falling test clock edge
  // ----------------------------------------------------------------
  always_comb begin
    if (state == ST_SHIFT_IR) begin
      serial_bit = ir_shift_ff[0];
    end else if (ir_ff == `IR_IDCODE) begin
      serial_bit = id_shift_ff[0];
    end else if (sel_bsr) begin
      serial_bit = bsr_shift_ff[0];
    end else begin
      serial_bit = bypass_ff;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (tap_rst) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (evt.fall) begin
      tdo_out    <= serial_bit;
      tdo_oe_out <= state == ST_SHIFT_DR || state == ST_SHIFT_IR;
    end
  end

endmodule : jtag_instruction_logic

// File: sim/jil_props.sv
// Purpose: port checks for the test access port instruction logic
// Assumes: tck held 5 sys clocks per phase by the tester
// Notes:   one clock domain, so default clocking
`timescale 1ns/100ps
`include "jtag_defines.svh"
module jil_props (
  input wire logic                  sys_clk_in,
  input wire logic                  nrst_in,
  input wire jtag_pkg::tap_pins_t   pins_in,
  input wire logic [`BSR_WIDTH-1:0] core_out_in,
  input wire logic [`BSR_WIDTH-1:0] core_oe_in,
  input wire logic [`BSR_WIDTH-1:0] pad_in,
  input wire logic                  tdo_out,
  input wire logic                  tdo_oe_out,
  input wire logic [`BSR_WIDTH-1:0] pad_out,
  input wire logic [`BSR_WIDTH-1:0] pad_oe_out,
  input wire logic [`IR_WIDTH-1:0]  instr_out,
  input wire logic                  reserved_sel_out
);
  import jtag_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic known;
  assign known = instr_out inside {`IR_EXTEST, `IR_SAMPLE, `IR_IDCODE,
                                   `IR_HIGHZ, `IR_CLAMP, `IR_BYPASS};
  // ----
  // checks
  // ----
  trst_idcode_a: assert property (!pins_in.trst_n [*6] |->
    instr_out == `IR_IDCODE) else $error("idcode not current");
  reserved_flag_a: assert property (
    ($stable(instr_out) && instr_out != `IR_CAPTURE_IR_DEFAULT_PATTERN) [*3]
    |-> reserved_sel_out == !known) else $error("reserved flag wrong");
  reset_quiet_a: assert property (!pins_in.trst_n [*6] |->
    !tdo_oe_out) else $error("tdo driven in reset");
  highz_off_a: assert property ((instr_out == `IR_HIGHZ) [*3] |->
    pad_oe_out == '0) else $error("enables on under highz");
  sample_pass_a: assert property ((instr_out == `IR_SAMPLE &&
    $stable(core_out_in) && $stable(core_oe_in)) [*3]
    |-> pad_out == core_out_in && pad_oe_out == core_oe_in)
    else $error("sample disturbs pads");
  clamp_hold_a: assert property ((instr_out == `IR_CLAMP) [*4] |->
    $stable(pad_out) && $stable(pad_oe_out)) else $error("clamp moved");
  tdo_fall_a: assert property ($changed(tdo_out) && tdo_oe_out |->
    !pins_in.tck) else $error("tdo moved with tck high");
  pins_still_a: assert property ($stable(pins_in) [*8] |->
    $stable(instr_out) && $stable(tdo_out)) else $error("idle change");
endmodule : jil_props

bind jtag_instruction_logic jil_props u_props (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .pins_in(pins_in),
  .core_out_in(core_out_in), .core_oe_in(core_oe_in), .pad_in(pad_in),
  .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .pad_out(pad_out),
  .pad_oe_out(pad_oe_out), .instr_out(instr_out),
  .reserved_sel_out(reserved_sel_out));

// File: sim/tap_tester.sv
// Purpose: board tester driving the test pins
// Assumes: 80 ns tck built from ten sys clocks
// Notes:   tck parked low and tdi at pull-up level between frames, tms left at its last value
`timescale 1ns/100ps
module tap_tester (
  input  wire logic                sys_clk_in,
  input  wire logic                tdo_in,
  output      jtag_pkg::tap_pins_t pins_out
);
  import jtag_pkg::*;
  // port held in reset until a test wants it
  initial pins_out = '{1'b0, 1'b1, 1'b1, 1'b0};
  // ----
  // pin tasks
  // ----
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge sys_clk_in);
    pins_out.tms <= tms;
    pins_out.tdi <= tdi;
    repeat (4) @(posedge sys_clk_in);
    tdo = tdo_in;
    pins_out.tck <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    pins_out.tck <= 1'b0;
  endtask : tick
  task automatic walk(input logic [7:0] path, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      tick(path[i], 1'b1, b);
  endtask : walk
  // shift n bits, then update and park in idle
  task automatic scan(input logic [31:0] din, input int n,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask : scan
  task automatic set_trst(input logic v);
    @(posedge sys_clk_in);
    pins_out.trst_n <= v;
    repeat (8) @(posedge sys_clk_in);
  endtask : set_trst
endmodule : tap_tester

// File: sim/testbench.sv
// Purpose: self-checking bench for the instruction logic
// Assumes: tester model owns the pins, bench owns core and pad side
// Notes:   only documented codes are loaded
`timescale 1ns/100ps
`include "jtag_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
  miscompares++; $display("wrong value at %0t: %h not %h", $time, a, b); \
  end end
module testbench;
  import jtag_pkg::*;
  logic       sys_clk_in = 1'b0;
  logic       nrst_in;
  logic [7:0] core_out_in, core_oe_in, pad_in, pad_out, pad_oe_out;
  logic [5:0] instr_out;
  logic       tdo_out, tdo_oe_out, reserved_sel_out;
  tap_pins_t  pins_in;
  logic [31:0] got;
  int         miscompares = 0;
  int         tests_run = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  jtag_instruction_logic u_dut (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .pins_in(pins_in), .core_out_in(core_out_in),
    .core_oe_in(core_oe_in), .pad_in(pad_in), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .instr_out(instr_out), .reserved_sel_out(reserved_sel_out));
  tap_tester u_tester (.sys_clk_in(sys_clk_in), .tdo_in(tdo_out),
    .pins_out(pins_in));
  // ----
  // scan helpers
  // ----
  task automatic load_ir(input logic [5:0] code);
    u_tester.walk(8'h03, 4);
    u_tester.scan({26'h0, code}, 6, got);
    repeat (2) @(posedge sys_clk_in);
    `CHK(got[5:0], `IR_CAPTURE_IR_DEFAULT_PATTERN)
    `CHK(instr_out, code)
  endtask : load_ir
  task automatic dr(input int n, input logic [31:0] din);
    u_tester.walk(8'h01, 3);
    u_tester.scan(din, n, got);
  endtask : dr
  // ----
  // scenarios
  // ----
  task automatic t_idcode;
    u_tester.set_trst(1'b1);
    u_tester.walk(8'h00, 1);
    dr(32, 32'hffff_ffff);
    `CHK(got[0], 1'b1)
    dr(32, 32'h0);
    `CHK(got, {4'h1, 16'h1234, 11'h155, 1'b1})
    $display("idcode test done");
  endtask : t_idcode
  task automatic t_boundary;
    core_out_in <= 8'ha5;
    core_oe_in <= 8'h3c;
    pad_in <= 8'h0f;
    load_ir(`IR_SAMPLE);
    dr(16, 32'hf096);
    `CHK(got[15:0], {8'h3c, 8'h24 | 8'h03})
    load_ir(`IR_EXTEST);
    `CHK({pad_oe_out, pad_out}, 16'hf096)
    dr(16, 32'h5a3c);
    `CHK({pad_oe_out, pad_out}, 16'h5a3c)
    load_ir(`IR_CLAMP);
    dr(8, 32'hdb);
    `CHK(got[7:0], 8'hb6)
    `CHK({pad_oe_out, pad_out}, 16'h5a3c)
    load_ir(`IR_HIGHZ);
    `CHK(pad_oe_out, 8'h00)
    $display("boundary test done");
  endtask : t_boundary
  task automatic t_bypass;
    load_ir(`IR_BYPASS);
    dr(8, 32'hdb);
    `CHK(got[7:0], 8'hb6)
    dr(1, 32'h1);
    `CHK(got[0], `BYPASS_CAPTURE)
    `CHK(reserved_sel_out, 1'b0)
    `CHK(tdo_oe_out, 1'b0)
    $display("bypass test done");
  endtask : t_bypass
  task automatic t_tms_reset;
    u_tester.walk(8'h1f, 5);
    repeat (6) @(posedge sys_clk_in);
    `CHK(instr_out, `IR_IDCODE)
    u_tester.walk(8'h00, 1);
    dr(1, 32'h0);
    `CHK(got[0], 1'b1)
    $display("mode select reset test done");
  endtask : t_tms_reset
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // ----
  // run
  // ----
  initial begin
    #200000;
    miscompares++;
    complete_run;
  end
  initial begin
    nrst_in = 1'b0;
    core_out_in = 8'h00;
    core_oe_in = 8'h00;
    pad_in = 8'h00;
    repeat (6) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    t_idcode;
    t_boundary;
    t_bypass;
    t_tms_reset;
    complete_run;
  end
endmodule : testbench
